/* core/ptsp_pkg.sv */
// Package: register map, field layout and constants of the time status and pulse unit
package ptsp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_SECONDS_UPPER_WORD = 12'h724;
  localparam logic [ADDR_W-1:0] OFS_TIME_STAMP_FLAGS = 12'h728;
  localparam logic [ADDR_W-1:0] OFS_PULSE_OUTPUT_CONTROL = 12'h72c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h740;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h744;

  // ----------------------------------------------------------------
  // Field widths and positions
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int UPPER_W = 16;
  localparam int SECONDS_W = 32;
  localparam int SUBSEC_W = 31;
  localparam int FREQ_W = 4;
  localparam int FLAG_SEC_OVF = 0;
  localparam int FLAG_TGT_REACHED = 1;
  localparam int FLAG_TGT_ERROR = 3;
  localparam int FLAG_W = 4;
  localparam int AUX_COUNT_LSB = 25;
  localparam int AUX_COUNT_MSB = 27;

  // Interrupt event positions in the status and mask registers
  localparam int EV_SEC_OVF = 0;
  localparam int EV_TGT_REACHED = 1;
  localparam int EV_TGT_ERROR = 2;
  localparam int NUM_EV = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [UPPER_W-1:0] RST_UPPER = 16'h0000;
  localparam logic [FREQ_W-1:0] RST_FREQ = 4'h0;
  localparam logic [NUM_EV-1:0] RST_IRQ_MASK = 3'h0;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // Highest sub-second bit; with a nonzero frequency code n the pulse follows bit TOP_SUBSEC_BIT - n
  localparam logic [4:0] TOP_SUBSEC_BIT = 5'h1e;
  // Last nanosecond value before the seconds carry in decimal rollover
  localparam logic [SUBSEC_W-1:0] DECIMAL_NS_MAX = 31'h3b9ac9ff;

endpackage

/* core/ptsp_time_if.sv */
// Interface: system time carried from the register block to the pulse generator
`timescale 1ns/1ps
interface ptsp_time_if;
  logic [31:0] secondsLow;
  logic [30:0] subseconds;
  logic decimalMode;
  modport src (output secondsLow, output subseconds, output decimalMode);
  modport snk (input secondsLow, input subseconds, input decimalMode);
endinterface

/* core/ptsp_sticky_flag.sv */
// Sticky flag bank: hardware set wins over a clear in the same cycle
`timescale 1ns/1ps
module ptsp_sticky_flag #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Set and clear strobes
  input wire logic [W-1:0] setEv,
  input wire logic [W-1:0] clrEv,
  // Flags
  output logic [W-1:0] flag
);

  logic [W-1:0] flag_reg;
  logic [W-1:0] flag_next;

  assign flag_next = setEv | (flag_reg & ~clrEv);
  assign flag = flag_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

endmodule

/* core/ptsp_pulse_gen.sv */
// Pulse-per-second generator driven from the system time counter bits
`timescale 1ns/1ps
module ptsp_pulse_gen
  import ptsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // System time
  ptsp_time_if.snk timeBus,
  // Control
  input wire logic [ptsp_pkg::FREQ_W-1:0] freqSel,
  // Pulse output
  output logic ppsOut
);

  import ptsp_pkg::*;

  logic ppsOut_reg;
  logic ppsOut_next;
  logic prevSecLsb_reg;
  logic primed_reg;
  logic [4:0] bitIdx;
  logic secondStep;

  // The same counter bit serves both modes; in decimal mode its weight
  // makes the average frequency half and the periods uneven
  assign bitIdx = TOP_SUBSEC_BIT - {1'b0, freqSel};
  assign secondStep = primed_reg && (timeBus.secondsLow[0] != prevSecLsb_reg);
  assign ppsOut_next = (freqSel == RST_FREQ) ? secondStep
                     : timeBus.subseconds[bitIdx];
  assign ppsOut = ppsOut_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ppsOut_reg <= 1'b0;
      prevSecLsb_reg <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      ppsOut_reg <= ppsOut_next;
      prevSecLsb_reg <= timeBus.secondsLow[0];
      primed_reg <= 1'b1;
    end
  end

endmodule

/* core/ptsp_top.sv */
// Time status, upper seconds word and pulse output block with APB register access
`timescale 1ns/1ps

// Summary of operation
// - Upper 16 bits of the 48-bit seconds count live in their own register.
// - Software writes the upper seconds word directly; the block loads it.
// - Upper seconds word increments by one on each lower 32-bit seconds overflow.
// - Reading the flags register clears the status bits that the read returned; bits 27 to 25 are not cleared.
// - Target-error flag sets when a programmed target has already elapsed; clears on read.
// - Target-reached flag sets when system time is at or past the target.
// - Seconds-overflow flag sets when the 32-bit seconds count overflows.
// - Frequency code zero gives one clock-wide pulse per second.
// - Nonzero code in binary rollover gives a clock of 2 to the code hertz.
// - Binary rollover pulse clock has a 50 percent duty cycle.
// - Decimal rollover gives half frequency on average, realigned each second.
// - Decimal code 1: low about 537 ms, then high about 463 ms.
// - Decimal code 2: one 537 ms period, then 268 ms low, 195 ms high.
// - Decimal code 3: three 268 ms periods, then 134 ms low, 61 ms high.
// - Auxiliary snapshot count field reads zero and is untouched by reads.
// - Decimal rollover sub-seconds step in 1 ns and wrap after 999,999,999.
// - Reaching the target time raises an interrupt event when enabled.
module ptsp_top
  import ptsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ptsp_pkg::ADDR_W-1:0] paddr,
  input wire logic [ptsp_pkg::DATA_W-1:0] pwdata,
  output logic [ptsp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // System time from the counter
  input wire logic [ptsp_pkg::SECONDS_W-1:0] secondsLow,
  input wire logic [ptsp_pkg::SUBSEC_W-1:0] subseconds,
  input wire logic secondsCarry,
  input wire logic decimalRolloverSelect,
  // Target time registers
  input wire logic [ptsp_pkg::SECONDS_W-1:0] targetSeconds,
  input wire logic [ptsp_pkg::SUBSEC_W-1:0] targetNanoseconds,
  input wire logic targetWritten,
  // Outputs
  output logic [ptsp_pkg::UPPER_W-1:0] upperSecondsCount,
  output logic pulsePerSecondOut,
  output logic irq
);

  import ptsp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic {
    ACC_IDLE = 1'b0,
    ACC_RESP = 1'b1
  } ptsp_apb_state_t;

  ptsp_apb_state_t apbState_reg;
  ptsp_apb_state_t apbState_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic [UPPER_W-1:0] upper_reg;
  logic [UPPER_W-1:0] upper_next;
  logic [FREQ_W-1:0] freq_reg;
  logic [NUM_EV-1:0] irqMask_reg;
  logic irq_reg;
  logic armed_reg;
  logic armed_next;
  logic [FREQ_W-1:0] freq_next;
  logic [NUM_EV-1:0] irqMask_next;
  logic irq_next;

  logic accessPhase;
  logic xferDone;
  logic wrDone;
  logic rdDone;
  logic selUpper;
  logic selFlags;
  logic selCtrl;
  logic selIrqStat;
  logic selIrqMask;
  logic addrHit;
  logic [DATA_W-1:0] readMux;
  logic wrUpper;
  logic wrCtrl;
  logic wrIrqMask;
  logic wrIrqStat;
  logic rdFlags;
  logic captureRead;
  logic [DATA_W-1:0] rdWordUpper;
  logic [DATA_W-1:0] rdWordFlags;
  logic [DATA_W-1:0] rdWordCtrl;
  logic [DATA_W-1:0] rdWordIrqStat;
  logic [DATA_W-1:0] rdWordIrqMask;

  logic secOnly;
  logic timeGeTarget;
  logic reachedEv;
  logic errorEv;
  logic secEqual;
  logic nsReached;
  logic ovfEv;
  logic [UPPER_W-1:0] upperInc;

  logic [FLAG_W-1:0] flagSet;
  logic [FLAG_W-1:0] flagClr;
  logic [FLAG_W-1:0] flags;
  logic [NUM_EV-1:0] irqSet;
  logic [NUM_EV-1:0] irqClr;
  logic [NUM_EV-1:0] irqStatus;

  ptsp_time_if timeBus ();

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  assign accessPhase = psel && penable;
  assign xferDone = accessPhase && pready_reg;
  assign wrDone = xferDone && pwrite;
  assign rdDone = xferDone && !pwrite;

  assign selUpper = (paddr == OFS_SECONDS_UPPER_WORD);
  assign selFlags = (paddr == OFS_TIME_STAMP_FLAGS);
  assign selCtrl = (paddr == OFS_PULSE_OUTPUT_CONTROL);
  assign selIrqStat = (paddr == OFS_IRQ_STATUS);
  assign selIrqMask = (paddr == OFS_IRQ_MASK);
  assign addrHit = selUpper || selFlags || selCtrl || selIrqStat || selIrqMask;

  // ----------------------------------------------------------------
  // Write and read strobes
  // ----------------------------------------------------------------
  assign wrUpper = wrDone && selUpper;
  assign wrCtrl = wrDone && selCtrl;
  assign wrIrqMask = wrDone && selIrqMask;
  assign wrIrqStat = wrDone && selIrqStat;
  assign rdFlags = rdDone && selFlags;
  // Read data are latched in the first access cycle and stand with pready
  assign captureRead = accessPhase && !pready_reg && !pwrite;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Auxiliary snapshot fields and all reserved bits read as zero
  assign rdWordUpper = {{(DATA_W-UPPER_W){1'b0}}, upper_reg};
  assign rdWordFlags = {{(DATA_W-FLAG_W){1'b0}}, flags};
  assign rdWordCtrl = {{(DATA_W-FREQ_W){1'b0}}, freq_reg};
  assign rdWordIrqStat = {{(DATA_W-NUM_EV){1'b0}}, irqStatus};
  assign rdWordIrqMask = {{(DATA_W-NUM_EV){1'b0}}, irqMask_reg};

  assign readMux = selUpper ? rdWordUpper
                 : selFlags ? rdWordFlags
                 : selCtrl ? rdWordCtrl
                 : selIrqStat ? rdWordIrqStat
                 : selIrqMask ? rdWordIrqMask
                 : '0;
  assign prdata_next = captureRead ? readMux : prdata_reg;

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  // One response cycle follows each first access cycle
  always_comb begin
    apbState_next = apbState_reg;
    case (apbState_reg)
      ACC_IDLE: begin
        if (accessPhase) begin
          apbState_next = ACC_RESP;
        end
      end
      ACC_RESP: begin
        apbState_next = ACC_IDLE;
      end
      default: begin
        apbState_next = ACC_IDLE;
      end
    endcase
  end

  // Unmapped addresses answer with an error and read as zero
  assign pready_next = (apbState_next == ACC_RESP);
  assign pslverr_next = pready_next && !addrHit;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      apbState_reg <= ACC_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      apbState_reg <= apbState_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // Upper seconds word
  // ----------------------------------------------------------------
  // A software write takes priority over a carry in the same cycle
  assign upperInc = upper_reg + 16'h0001;
  assign upper_next = wrUpper ? pwdata[UPPER_W-1:0]
                    : secondsCarry ? upperInc
                    : upper_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      upper_reg <= RST_UPPER;
    end else begin
      upper_reg <= upper_next;
    end
  end

  assign upperSecondsCount = upper_reg;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Only the low field bits are kept; reserved bits of a write are dropped
  assign freq_next = wrCtrl ? pwdata[FREQ_W-1:0] : freq_reg;
  assign irqMask_next = wrIrqMask ? pwdata[NUM_EV-1:0] : irqMask_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      freq_reg <= RST_FREQ;
    end else begin
      freq_reg <= freq_next;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqMask_reg <= RST_IRQ_MASK;
    end else begin
      irqMask_reg <= irqMask_next;
    end
  end

  // ----------------------------------------------------------------
  // Target time comparison
  // ----------------------------------------------------------------
  // Nanosecond targets are compared in the counter's own units, so the
  // decimal wrap at DECIMAL_NS_MAX needs no special handling here
  assign secOnly = (secondsLow > targetSeconds);
  assign secEqual = (secondsLow == targetSeconds);
  assign nsReached = (subseconds >= targetNanoseconds);
  assign timeGeTarget = secOnly || (secEqual && nsReached);

  // A target programmed into the past is reported and never armed
  assign errorEv = targetWritten && timeGeTarget;
  assign reachedEv = armed_reg && timeGeTarget && !targetWritten;
  assign armed_next = targetWritten ? !timeGeTarget
                    : reachedEv ? 1'b0
                    : armed_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
    end
  end

  // ----------------------------------------------------------------
  // Time stamp flags (clear on read)
  // ----------------------------------------------------------------
  assign ovfEv = secondsCarry;

  always_comb begin
    flagSet = '0;
    flagSet[FLAG_SEC_OVF] = ovfEv;
    flagSet[FLAG_TGT_REACHED] = reachedEv;
    flagSet[FLAG_TGT_ERROR] = errorEv;
  end

  // A completed read clears the bits that it reported; an event that lands
  // after the data were latched stays set for the next read
  assign flagClr = rdFlags ? prdata_reg[FLAG_W-1:0] : '0;

  ptsp_sticky_flag #(
    .W(FLAG_W)
  ) u_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .setEv(flagSet),
    .clrEv(flagClr),
    .flag(flags)
  );

  // ----------------------------------------------------------------
  // Interrupt status (write one to clear) and mask
  // ----------------------------------------------------------------
  assign irqSet = {errorEv, reachedEv, ovfEv};
  assign irqClr = wrIrqStat ? pwdata[NUM_EV-1:0] : '0;

  ptsp_sticky_flag #(
    .W(NUM_EV)
  ) u_irq_status (
    .clk(clk),
    .sys_rst(sys_rst),
    .setEv(irqSet),
    .clrEv(irqClr),
    .flag(irqStatus)
  );

  assign irq_next = |(irqStatus & irqMask_reg);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Pulse output
  // ----------------------------------------------------------------
  assign timeBus.secondsLow = secondsLow;
  assign timeBus.subseconds = subseconds;
  assign timeBus.decimalMode = decimalRolloverSelect;

  ptsp_pulse_gen u_pulse (
    .clk(clk),
    .sys_rst(sys_rst),
    .timeBus(timeBus.snk),
    .freqSel(freq_reg),
    .ppsOut(pulsePerSecondOut)
  );

endmodule

/* test/ptsp_monitor.sv */
// Checker: port-level assertions for the time status and pulse block
`timescale 1ns/1ps
module ptsp_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ptsp_pkg::ADDR_W-1:0] paddr,
  input wire logic [ptsp_pkg::DATA_W-1:0] pwdata,
  input wire logic [ptsp_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Time
  input wire logic secondsCarry,
  input wire logic [ptsp_pkg::UPPER_W-1:0] upperSecondsCount
);
  import ptsp_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic done;
  logic wrUp;
  logic rdFlags;
  logic rdFlagsAcc;
  assign done = psel && penable && pready;
  assign wrUp = done && pwrite && paddr == OFS_SECONDS_UPPER_WORD;
  assign rdFlags = done && !pwrite && paddr == OFS_TIME_STAMP_FLAGS;
  assign rdFlagsAcc = psel && penable && !pready && !pwrite && paddr == OFS_TIME_STAMP_FLAGS;
  // ----
  // Assertions
  // ----
  a_ready_second: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_write_loads: assert property (wrUp |=> upperSecondsCount == $past(pwdata[15:0]))
    else $error("upper word not loaded");
  a_carry_steps: assert property (secondsCarry && !wrUp |=>
    upperSecondsCount == $past(upperSecondsCount) + 16'h0001)
    else $error("upper word not incremented");
  a_upper_holds: assert property (!secondsCarry && !wrUp |=> $stable(upperSecondsCount))
    else $error("upper word changed without cause");
  a_flags_reserved: assert property (rdFlags |-> prdata[31:4] == 28'h0 && !prdata[2])
    else $error("reserved flag bits not zero");
  a_ovf_flagged: assert property (secondsCarry ##[1:2] rdFlagsAcc |=> prdata[FLAG_SEC_OVF])
    else $error("overflow flag missing");
  a_err_zero: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("bad error response");
  c_flags: cover property (rdFlags);
  c_carry: cover property (secondsCarry);
  c_err: cover property (pslverr);
endmodule
bind ptsp_top ptsp_monitor u_mon (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .secondsCarry, .upperSecondsCount);

/* test/tb_top.sv */
// Testbench: register, flag, interrupt and pulse output tests
`timescale 1ns/1ps
module tb_top;
  import ptsp_pkg::*;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic secondsCarry, decimalRolloverSelect, targetWritten, pulsePerSecondOut, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [SECONDS_W-1:0] secondsLow, targetSeconds;
  logic [SUBSEC_W-1:0] subseconds, targetNanoseconds;
  logic [UPPER_W-1:0] upperSecondsCount;
  int n_mismatch, tests_run, cnt;
  ptsp_top dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .secondsLow, .subseconds, .secondsCarry, .decimalRolloverSelect, .targetSeconds,
    .targetNanoseconds, .targetWritten, .upperSecondsCount, .pulsePerSecondOut, .irq);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic pulse_in(input bit tw);
    @(posedge clk);
    if (tw) targetWritten <= 1'b1;
    else secondsCarry <= 1'b1;
    @(posedge clk);
    targetWritten <= 1'b0;
    secondsCarry <= 1'b0;
  endtask
  task automatic look(input logic v, input logic exp);
    check({31'h0, v}, {31'h0, exp});
    @(posedge clk);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    {psel, penable, pwrite, secondsCarry, decimalRolloverSelect, targetWritten} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    secondsLow = 32'h0;
    subseconds = 31'h0;
    targetSeconds = 32'h0;
    targetNanoseconds = 31'h0;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(OFS_SECONDS_UPPER_WORD, 32'h0);
    rd_chk(OFS_TIME_STAMP_FLAGS, 32'h0);
    rd_chk(OFS_PULSE_OUTPUT_CONTROL, 32'h0);
    rd_chk(OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_SECONDS_UPPER_WORD, 32'hffffabcd);
    rd_chk(OFS_SECONDS_UPPER_WORD, 32'h0000abcd);
    check({16'h0, upperSecondsCount}, 32'h0000abcd);
    apb(1'b1, OFS_SECONDS_UPPER_WORD, 32'h0000ffff);
    pulse_in(1'b0);
    rd_chk(OFS_SECONDS_UPPER_WORD, 32'h0);
    pulse_in(1'b0);
    pulse_in(1'b0);
    rd_chk(OFS_SECONDS_UPPER_WORD, 32'h2);
    rd_chk(OFS_TIME_STAMP_FLAGS, 32'h1);
    rd_chk(OFS_TIME_STAMP_FLAGS, 32'h0);
    // Overflow just before the data are latched, then one in the clearing cycle
    fork apb(1'b0, OFS_TIME_STAMP_FLAGS, 32'h0); pulse_in(1'b0); join
    check(rd, 32'h1);
    fork apb(1'b0, OFS_TIME_STAMP_FLAGS, 32'h0); begin repeat (2) @(posedge clk); pulse_in(1'b0); end join
    check(rd, 32'h0);
    rd_chk(OFS_TIME_STAMP_FLAGS, 32'h1);
    rd_chk(12'h700, 32'h0);
    check({31'h0, er}, 32'h1);
    secondsLow <= 32'd10;
    targetSeconds <= 32'd5;
    pulse_in(1'b1);
    rd_chk(OFS_TIME_STAMP_FLAGS, 32'h8);
    rd_chk(OFS_TIME_STAMP_FLAGS, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    targetSeconds <= 32'd20;
    pulse_in(1'b1);
    repeat (3) @(posedge clk);
    @(negedge clk) look(irq, 1'b0);
    secondsLow <= 32'd20;
    repeat (3) @(posedge clk);
    @(negedge clk) look(irq, 1'b1);
    rd_chk(OFS_TIME_STAMP_FLAGS, 32'h2);
    rd_chk(OFS_IRQ_STATUS, 32'h7);
    apb(1'b1, OFS_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    @(negedge clk) look(irq, 1'b0);
    rd_chk(OFS_IRQ_STATUS, 32'h5);
    secondsLow <= 32'd21;
    cnt = 0;
    repeat (8) @(negedge clk) if (pulsePerSecondOut === 1'b1) cnt++;
    check(cnt, 1);
    for (int n = 1; n < 16; n++) begin
      apb(1'b1, OFS_PULSE_OUTPUT_CONTROL, {28'hfffffff, 4'(n)});
      rd_chk(OFS_PULSE_OUTPUT_CONTROL, {28'h0, 4'(n)});
      decimalRolloverSelect <= n[0];
      subseconds <= 31'h1 << (30 - n);
      repeat (3) @(posedge clk);
      @(negedge clk) look(pulsePerSecondOut, 1'b1);
      subseconds <= ~(31'h1 << (30 - n));
      repeat (3) @(posedge clk);
      @(negedge clk) look(pulsePerSecondOut, 1'b0);
    end
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule
